/* hdl/dpps_sequencer.v */
// Power-up sequencer for a two-PLL clock generator.
// Overview of operation
// - The device enable stays low until both supply-good inputs are high, though the host port is already enabled.
// - With a crystal in use and power-down released, it waits for the crystal amplitude detector.
// - It then runs the first PLL calibration wait in programmable internal oscillator ticks.
// - It then runs the first VCO wait in programmable internal oscillator ticks.
// - A PLL's outputs are enabled as soon as its calibration and VCO waits finish.
// - The first PLL loss-of-lock flag drops a phase-detector period after that PLL locks.
// - It runs the second PLL calibration wait in programmable internal oscillator ticks.
// - It then runs the second VCO wait in programmable internal oscillator ticks.
// - The second PLL loss-of-lock flag drops a phase-detector period after that PLL locks.
// - With the independent-start bit low, the second PLL starts after the first PLL's whole start-up.
// - With the independent-start bit high, the second PLL starts right after the crystal stage.
// - While the power-down pin is low all functions and the serial host port are disabled.
// - Releasing the power-down pin resets state, loads the strapped configuration and starts the sequence.
`timescale 1ns/100ps
`include "dpps_defs.vh"
module dpps_sequencer #(
	parameter CW = `DPPS_CNT_W,
	parameter PW = `DPPS_PFD_W
)
(
	input wire CLK,
	input wire RST_N,
	input wire POWERDOWN_PIN_LOW_ACTIVE_N,
	input wire CORE_SUPPLY_GOOD,
	input wire OUTPUT_BANK_ZERO_SUPPLY_GOOD,
	input wire CRYSTAL_IN_USE,
	input wire CRYSTAL_AMPLITUDE_OK,
	input wire PLL2_INDEPENDENT_START_BIT,
	input wire [CW-1:0] PLL1_CALIBRATION_WAIT,
	input wire [CW-1:0] VCO1_SETTLE_WAIT,
	input wire [CW-1:0] PLL2_CALIBRATION_WAIT,
	input wire [CW-1:0] VCO2_SETTLE_WAIT,
	input wire [PW-1:0] PFD_PERIOD_CYCLES,
	input wire PLL1_LOCKED,
	input wire PLL2_LOCKED,
	input wire STATUS_PIN_ZERO_SELECT_PLL2,
	input wire STATUS_PIN_ONE_SELECT_PLL2,
	output reg DEVICE_ENABLE,
	output reg HOST_PORT_ENABLE,
	output reg CONFIG_LOAD,
	output reg PLL1_OUTPUT_ENABLE,
	output reg PLL2_OUTPUT_ENABLE,
	output reg PLL1_LOSS_OF_LOCK_FLAG,
	output reg PLL2_LOSS_OF_LOCK_FLAG,
	output reg STATUS_PIN_ZERO,
	output reg STATUS_PIN_ONE,
	output reg SEQUENCE_DONE
);
	// One-hot main states.
	localparam ST_OFF = 5'h01;
	localparam ST_SUPPLY = 5'h02;
	localparam ST_CRYSTAL = 5'h04;
	localparam ST_RUN = 5'h08;
	localparam ST_DONE = 5'h10;
	// Number of PLL start-up chains.
	localparam NUM_PLL = 2;

	reg [4:0] state_r;
	reg [4:0] state_nxt;
	reg released_r;
	reg [1:0] osc_div_r;
	reg osc_tick_r;
	reg ind_start_r;
	reg pll1_go_r;
	reg pll2_go_r;
	wire abort;
	wire [NUM_PLL-1:0] chain_go;
	wire [NUM_PLL-1:0] cal_done;
	wire [NUM_PLL-1:0] vco_done;
	wire [NUM_PLL-1:0] lock_in;
	wire [NUM_PLL-1:0] flag_nxt;
	wire [NUM_PLL*CW-1:0] cal_len;
	wire [NUM_PLL*CW-1:0] vco_len;
	wire pll1_up;
	wire pll2_up;
	genvar g;

	// Power-down low or reset clears every counter so a new release starts clean.
	// abort and clear
	assign abort = !RST_N || !POWERDOWN_PIN_LOW_ACTIVE_N;

	// Internal 10 MHz oscillator modelled as a tick every OSC_DIV system clocks.
	always @(posedge CLK)
	begin
		if (abort || osc_div_r == (`DPPS_OSC_DIV - 1))
			osc_div_r <= 2'h0;
		else
			osc_div_r <= osc_div_r + 2'h1;
		osc_tick_r <= !abort && (osc_div_r == (`DPPS_OSC_DIV - 1));
	end

	// Main state transitions.
	always @*
	begin
		state_nxt = state_r;
		case (state_r)
			ST_OFF:
				state_nxt = ST_SUPPLY;
			ST_SUPPLY:
				if (CORE_SUPPLY_GOOD && OUTPUT_BANK_ZERO_SUPPLY_GOOD)
					state_nxt = ST_CRYSTAL;
			ST_CRYSTAL:
				if (!CRYSTAL_IN_USE || CRYSTAL_AMPLITUDE_OK)
					state_nxt = ST_RUN;
			ST_RUN:
				if (pll1_up && pll2_up)
					state_nxt = ST_DONE;
			ST_DONE:
				state_nxt = ST_DONE;
			default:
				state_nxt = ST_OFF;
		endcase
	end

	// State register plus the release edge detector on the power-down pin.
	always @(posedge CLK)
	begin
		if (abort)
		begin
			state_r <= ST_OFF;
			released_r <= 1'b0;
		end
		else
		begin
			released_r <= 1'b1;
			state_r <= state_nxt;
		end
	end

	// Strapped configuration is captured once, on the cycle after release.
	// load strapped configuration
	always @(posedge CLK)
	begin
		if (abort)
		begin
			ind_start_r <= 1'b0;
			CONFIG_LOAD <= 1'b0;
		end
		else
		begin
			CONFIG_LOAD <= !released_r;
			if (!released_r)
				ind_start_r <= PLL2_INDEPENDENT_START_BIT;
		end
	end

	// Start gates for the two PLL chains; the second waits on the first unless started independently.
	always @(posedge CLK)
	begin
		if (abort)
		begin
			pll1_go_r <= 1'b0;
			pll2_go_r <= 1'b0;
		end
		else
		begin
			pll1_go_r <= (state_r == ST_RUN) || (state_r == ST_DONE);
			pll2_go_r <= ((state_r == ST_RUN) || (state_r == ST_DONE)) && (ind_start_r || pll1_up);
		end
	end

	// Per-PLL inputs are packed so that one loop builds both start-up chains, PLL1 in slot 0.
	assign chain_go = {pll2_go_r, pll1_go_r};
	assign cal_len = {PLL2_CALIBRATION_WAIT, PLL1_CALIBRATION_WAIT};
	assign vco_len = {VCO2_SETTLE_WAIT, VCO1_SETTLE_WAIT};
	assign lock_in = {PLL2_LOCKED, PLL1_LOCKED};

	// Each chain runs its calibration wait, then its VCO wait, then times its lock indicator.
	generate
		for (g = 0; g < NUM_PLL; g = g + 1)
		begin : g_chain
			reg [PW-1:0] pfd_cnt_r;
			wire locked_now;
			wire period_done;

			dpps_wait_timer #(.CW(CW)) u_cal (
				.clk(CLK), .rst_n(RST_N), .clear(abort), .start(chain_go[g]), .tick(osc_tick_r),
				.length(cal_len[g*CW +: CW]), .done(cal_done[g]));
			dpps_wait_timer #(.CW(CW)) u_vco (
				.clk(CLK), .rst_n(RST_N), .clear(abort), .start(cal_done[g]), .tick(osc_tick_r),
				.length(vco_len[g*CW +: CW]), .done(vco_done[g]));

			// Lock only counts once the VCO wait is over, so an early lock report cannot clear the flag.
			assign locked_now = vco_done[g] && lock_in[g];
			assign period_done = (pfd_cnt_r + {{(PW-1){1'b0}}, 1'b1}) >= PFD_PERIOD_CYCLES;

			always @(posedge CLK)
			begin
				if (abort || !locked_now)
					pfd_cnt_r <= {PW{1'b0}};
				else if (!period_done)
					pfd_cnt_r <= pfd_cnt_r + {{(PW-1){1'b0}}, 1'b1};
			end

			// The flag may drop only after a whole phase-detector period of steady lock.
			assign flag_nxt[g] = !(locked_now && period_done);
		end
	endgenerate

	// A PLL's start-up is complete once its outputs are on and it reports lock.
	assign pll1_up = vco_done[0] && !PLL1_LOSS_OF_LOCK_FLAG;
	assign pll2_up = vco_done[1] && !PLL2_LOSS_OF_LOCK_FLAG;

	// Loss-of-lock flags are not sticky: losing lock raises them again on the next edge.
	always @(posedge CLK)
	begin
		if (abort)
		begin
			PLL1_LOSS_OF_LOCK_FLAG <= 1'b1;
			PLL2_LOSS_OF_LOCK_FLAG <= 1'b1;
		end
		else
		begin
			PLL1_LOSS_OF_LOCK_FLAG <= flag_nxt[0];
			PLL2_LOSS_OF_LOCK_FLAG <= flag_nxt[1];
		end
	end

	// Registered outputs; enables and done are held low and both status pins high while the pin is low.
	always @(posedge CLK)
	begin
		if (abort)
		begin
			DEVICE_ENABLE <= 1'b0;
			HOST_PORT_ENABLE <= 1'b0;
			PLL1_OUTPUT_ENABLE <= 1'b0;
			PLL2_OUTPUT_ENABLE <= 1'b0;
			STATUS_PIN_ZERO <= 1'b1;
			STATUS_PIN_ONE <= 1'b1;
			SEQUENCE_DONE <= 1'b0;
		end
		else
		begin
			DEVICE_ENABLE <= (state_r != ST_OFF) && (state_r != ST_SUPPLY);
			HOST_PORT_ENABLE <= 1'b1;
			PLL1_OUTPUT_ENABLE <= vco_done[0];
			PLL2_OUTPUT_ENABLE <= vco_done[1];
			STATUS_PIN_ZERO <= STATUS_PIN_ZERO_SELECT_PLL2 ? PLL2_LOSS_OF_LOCK_FLAG : PLL1_LOSS_OF_LOCK_FLAG;
			STATUS_PIN_ONE <= STATUS_PIN_ONE_SELECT_PLL2 ? PLL2_LOSS_OF_LOCK_FLAG : PLL1_LOSS_OF_LOCK_FLAG;
			SEQUENCE_DONE <= (state_r == ST_DONE);
		end
	end
endmodule

/* hdl/dpps_defs.vh */
// Constants shared by the dual PLL power-up sequencer.
`ifndef DPPS_DEFS_VH
`define DPPS_DEFS_VH
`define DPPS_CLK_HZ 20000000
`define DPPS_OSC_HZ 10000000
`define DPPS_OSC_DIV (`DPPS_CLK_HZ / `DPPS_OSC_HZ)
`define DPPS_CNT_W 24
`define DPPS_CAL_DEF 24'h000bb8
`define DPPS_VCO_DEF 24'h000fa0
`define DPPS_PFD_DEF 16'h0002
`define DPPS_PFD_W 16
`endif

/* hdl/dpps_wait_timer.v */
// Wait timer counting a programmed number of internal oscillator ticks.
`timescale 1ns/100ps
`include "dpps_defs.vh"
module dpps_wait_timer #(
	parameter CW = `DPPS_CNT_W
)
(
	input wire clk,
	input wire rst_n,
	input wire clear,
	input wire start,
	input wire tick,
	input wire [CW-1:0] length,
	output reg done
);
	reg [CW-1:0] count_r;
	reg run_r;

	// Counts ticks from start; a zero length still takes one tick so no step is skipped.
	always @(posedge clk)
	begin
		if (!rst_n || clear)
		begin
			count_r <= {CW{1'b0}};
			run_r <= 1'b0;
			done <= 1'b0;
		end
		else if (start && !run_r && !done)
		begin
			count_r <= length;
			run_r <= 1'b1;
		end
		else if (run_r && tick)
		begin
			if (count_r <= {{(CW-1){1'b0}}, 1'b1})
			begin
				run_r <= 1'b0;
				done <= 1'b1;
			end
			else
				count_r <= count_r - {{(CW-1){1'b0}}, 1'b1};
		end
	end
endmodule

/* tb/dpps_far_side.sv */
// Far-side model: host power-down driver and PLL lock behaviour.
`timescale 1ns/100ps
module dpps_far_side (
	input wire clk,
	input wire pd_req,
	input wire oe1,
	input wire oe2,
	output reg pin_n = 1'b0,
	output reg lock1 = 1'b0,
	output reg lock2 = 1'b0
);
	reg [3:0] c1_r = 4'h0;
	reg [3:0] c2_r = 4'h0;
	// Locks follow each output enable after a settle time; PLL2 never rises on the edge PLL1 locks.
	// staggered lock
	always @(posedge clk)
	begin
		pin_n <= !pd_req;
		c1_r <= oe1 ? c1_r + {3'h0, c1_r != 4'hf} : 4'h0;
		c2_r <= oe2 ? c2_r + {3'h0, c2_r != 4'hf} : 4'h0;
		lock1 <= c1_r > 4'h3;
		lock2 <= (c2_r > 4'h9) && (lock2 || c1_r != 4'h4);
	end
endmodule

/* tb/dpps_props.sv */
// Port checker for the power-up sequencer.
`timescale 1ns/100ps
module dpps_props (
	input wire CLK,
	input wire RST_N,
	input wire POWERDOWN_PIN_LOW_ACTIVE_N,
	input wire CORE_SUPPLY_GOOD,
	input wire OUTPUT_BANK_ZERO_SUPPLY_GOOD,
	input wire CRYSTAL_AMPLITUDE_OK,
	input wire PLL2_INDEPENDENT_START_BIT,
	input wire PLL1_LOCKED,
	input wire PLL2_LOCKED,
	input wire STATUS_PIN_ZERO_SELECT_PLL2,
	input wire DEVICE_ENABLE,
	input wire HOST_PORT_ENABLE,
	input wire CONFIG_LOAD,
	input wire PLL1_OUTPUT_ENABLE,
	input wire PLL2_OUTPUT_ENABLE,
	input wire PLL1_LOSS_OF_LOCK_FLAG,
	input wire PLL2_LOSS_OF_LOCK_FLAG,
	input wire STATUS_PIN_ZERO
);
	wire pin_high = POWERDOWN_PIN_LOW_ACTIVE_N;
	wire oe1 = PLL1_OUTPUT_ENABLE;
	default clocking @(posedge CLK); endclocking
	default disable iff (!RST_N);
	// The bench fixes PLL1 waits at 3 and 2 ticks, so its enable lands in a narrow window.
	sequence s_p1_wait;
		!oe1 [*8];
	endsequence
	a_pdn_clears: assert property (!pin_high |=> !DEVICE_ENABLE && !HOST_PORT_ENABLE && !oe1 && !PLL2_OUTPUT_ENABLE)
		else $error("power-down left an output on");
	a_cfg_pulse: assert property ($rose(HOST_PORT_ENABLE) |-> CONFIG_LOAD ##1 !CONFIG_LOAD)
		else $error("config load not one cycle");
	a_supply_hold: assert property (!(CORE_SUPPLY_GOOD && OUTPUT_BANK_ZERO_SUPPLY_GOOD) && !DEVICE_ENABLE |=> !DEVICE_ENABLE)
		else $error("enabled without supplies");
	a_xtal_stall: assert property (!CRYSTAL_AMPLITUDE_OK && !oe1 && !PLL2_OUTPUT_ENABLE |=> !oe1 && !PLL2_OUTPUT_ENABLE)
		else $error("output before crystal ok");
	a_p1_waits: assert property (disable iff (!RST_N || !pin_high) $rose(DEVICE_ENABLE) && CRYSTAL_AMPLITUDE_OK |-> s_p1_wait ##[1:8] oe1)
		else $error("pll1 enable timing");
	a_p1_lol: assert property ($fell(PLL1_LOSS_OF_LOCK_FLAG) |-> $past(PLL1_LOCKED) && oe1)
		else $error("pll1 flag fell unlocked");
	a_p2_lol: assert property ($fell(PLL2_LOSS_OF_LOCK_FLAG) |-> $past(PLL2_LOCKED) && PLL2_OUTPUT_ENABLE)
		else $error("pll2 flag fell unlocked");
	a_serial_order: assert property ($rose(PLL2_OUTPUT_ENABLE) && !PLL2_INDEPENDENT_START_BIT |-> !PLL1_LOSS_OF_LOCK_FLAG)
		else $error("pll2 before pll1 in serial mode");
	a_status_map: assert property (disable iff (!RST_N || !pin_high) 1'b1 |=> STATUS_PIN_ZERO == ($past(STATUS_PIN_ZERO_SELECT_PLL2) ?
		$past(PLL2_LOSS_OF_LOCK_FLAG) : $past(PLL1_LOSS_OF_LOCK_FLAG)))
		else $error("status pin zero source");
endmodule
bind dpps_sequencer dpps_props u_props (
	.CLK(CLK),
	.RST_N(RST_N),
	.POWERDOWN_PIN_LOW_ACTIVE_N(POWERDOWN_PIN_LOW_ACTIVE_N),
	.CORE_SUPPLY_GOOD(CORE_SUPPLY_GOOD),
	.OUTPUT_BANK_ZERO_SUPPLY_GOOD(OUTPUT_BANK_ZERO_SUPPLY_GOOD),
	.CRYSTAL_AMPLITUDE_OK(CRYSTAL_AMPLITUDE_OK),
	.PLL2_INDEPENDENT_START_BIT(PLL2_INDEPENDENT_START_BIT),
	.PLL1_LOCKED(PLL1_LOCKED),
	.PLL2_LOCKED(PLL2_LOCKED),
	.STATUS_PIN_ZERO_SELECT_PLL2(STATUS_PIN_ZERO_SELECT_PLL2),
	.DEVICE_ENABLE(DEVICE_ENABLE),
	.HOST_PORT_ENABLE(HOST_PORT_ENABLE),
	.CONFIG_LOAD(CONFIG_LOAD),
	.PLL1_OUTPUT_ENABLE(PLL1_OUTPUT_ENABLE),
	.PLL2_OUTPUT_ENABLE(PLL2_OUTPUT_ENABLE),
	.PLL1_LOSS_OF_LOCK_FLAG(PLL1_LOSS_OF_LOCK_FLAG),
	.PLL2_LOSS_OF_LOCK_FLAG(PLL2_LOSS_OF_LOCK_FLAG),
	.STATUS_PIN_ZERO(STATUS_PIN_ZERO)
);

/* tb/testbench.sv */
// Self-checking bench for the power-up sequencer.
`timescale 1ns/100ps
module testbench;
	reg CLK = 1'b0;
	reg RST_N = 1'b0;
	reg pd_req = 1'b1;
	reg sup = 1'b0;
	reg amp = 1'b1;
	reg indep = 1'b0;
	reg sel0 = 1'b0;
	reg sel1 = 1'b0;
	reg [23:0] cal2 = 24'h000001;
	reg [23:0] vco2 = 24'h000001;
	wire pin_n, lk1, lk2, de, hpe, oe1, oe2, flag1, flag2, st0, st1, done;
	integer miscompares = 0;
	integer checked = 0;
	integer i, n, t1, t2;
	reg [19:0] rows [0:3];
	dpps_sequencer dut (.CLK(CLK), .RST_N(RST_N), .POWERDOWN_PIN_LOW_ACTIVE_N(pin_n), .CORE_SUPPLY_GOOD(sup),
		.OUTPUT_BANK_ZERO_SUPPLY_GOOD(sup), .CRYSTAL_IN_USE(1'b1), .CRYSTAL_AMPLITUDE_OK(amp),
		.PLL2_INDEPENDENT_START_BIT(indep), .PLL1_CALIBRATION_WAIT(24'h000003), .VCO1_SETTLE_WAIT(24'h000002),
		.PLL2_CALIBRATION_WAIT(cal2), .VCO2_SETTLE_WAIT(vco2), .PFD_PERIOD_CYCLES(16'h0004), .PLL1_LOCKED(lk1),
		.PLL2_LOCKED(lk2), .STATUS_PIN_ZERO_SELECT_PLL2(sel0), .STATUS_PIN_ONE_SELECT_PLL2(sel1),
		.DEVICE_ENABLE(de), .HOST_PORT_ENABLE(hpe), .CONFIG_LOAD(), .PLL1_OUTPUT_ENABLE(oe1),
		.PLL2_OUTPUT_ENABLE(oe2), .PLL1_LOSS_OF_LOCK_FLAG(flag1), .PLL2_LOSS_OF_LOCK_FLAG(flag2),
		.STATUS_PIN_ZERO(st0), .STATUS_PIN_ONE(st1), .SEQUENCE_DONE(done));
	dpps_far_side host (.clk(CLK), .pd_req(pd_req), .oe1(oe1), .oe2(oe2), .pin_n(pin_n), .lock1(lk1), .lock2(lk2));
	// Half period of the 20 MHz clock.
	always #25 CLK = ~CLK;
	task chk(input string nm, input logic e, input logic g);
	begin
		checked = checked + 1;
		if (g !== e)
		begin
			miscompares = miscompares + 1;
			$display("ERROR %s expected %b seen %b", nm, e, g);
		end
	end
	endtask
	task rel;
	begin
		@(posedge CLK) pd_req <= 1'b0;
	end
	endtask
	// Five edges: one for the request, one in the host model, one in the design, one to read, one spare.
	task pd;
	begin
		@(posedge CLK) pd_req <= 1'b1;
		repeat (4) @(posedge CLK);
	end
	endtask
	// Records the cycle of each output enable while waiting, bounded, for the whole start-up.
	task run;
	begin
		t1 = 0;
		t2 = 0;
		n = 0;
		while (done !== 1'b1 && n < 400)
		begin
			@(posedge CLK) n = n + 1;
			if (oe1 === 1'b1 && t1 == 0) t1 = n;
			if (oe2 === 1'b1 && t2 == 0) t2 = n;
		end
		chk("done", 1'b1, done);
	end
	endtask
	task finish_test;
	begin
		$display("checked %0d miscompares %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	end
	endtask
	// Rows: strap, status selects, PLL2 waits, then whether PLL2 comes up first.
	initial
	begin
		rows[0] = {1'b0, 1'b0, 1'b1, 8'h01, 8'h01, 1'b0};
		rows[1] = {1'b1, 1'b1, 1'b0, 8'h01, 8'h01, 1'b1};
		rows[2] = {1'b1, 1'b0, 1'b0, 8'h08, 8'h08, 1'b0};
		rows[3] = {1'b0, 1'b1, 1'b1, 8'h00, 8'h00, 1'b0};
		repeat (3) @(posedge CLK);
		RST_N <= 1'b1;
		sup <= 1'b1;
		@(posedge CLK);
		chk("dev en", 1'b0, de);
		chk("flag1", 1'b1, flag1);
		chk("status zero", 1'b1, st0);
		for (i = 0; i < 4; i = i + 1)
		begin
			{indep, sel0, sel1, cal2[7:0], vco2[7:0]} <= rows[i][19:1];
			rel;
			run;
			chk("pll2 first", rows[i][0], t2 < t1);
			chk("flag2", 1'b0, flag2);
			chk("status zero", 1'b0, st0);
			chk("status one", 1'b0, st1);
			pd;
		end
		sup <= 1'b0;
		rel;
		repeat (20) @(posedge CLK);
		chk("dev en", 1'b0, de);
		chk("host port", 1'b1, hpe);
		sup <= 1'b1;
		amp <= 1'b0;
		repeat (40) @(posedge CLK);
		chk("oe1", 1'b0, oe1);
		amp <= 1'b1;
		repeat (16) @(posedge CLK);
		chk("oe1", 1'b1, oe1);
		pd;
		chk("oe1", 1'b0, oe1);
		chk("host port", 1'b0, hpe);
		rel;
		run;
		finish_test;
	end
	// The whole run needs about four hundred cycles; eight thousand means a hang.
	initial
	begin
		#400000;
		miscompares = miscompares + 1;
		finish_test;
	end
endmodule
